// [src/gpmo_params.svh]
// constants of the masked gpio output-value block
// assumes a 32-bit classic wishbone slave at the core clock
// Contract
// R1: a 32-bit output-value register holds one independently set bit per pin, nine pins.
// R2: a write changes a pin's value bit only when its mask bit is 1 in that write.
// R3: mask bits are not stored and always read as 0.
// R4: a read returns every stored value bit whatever the pin's configuration.
// R5: a driving pin is high for a stored 1 and low for a stored 0.
// R6: a pin is driven only when selected as gpio and set as an output.
// R7: a direction bit of 0 means output and 1 means input.
// R8: pins 0 to 3 use value bits 0 to 3 and mask bits 4 to 7.
// R9: pins 4 to 7 use value bits 8 to 11 and mask bits 12 to 15.
// R10: pin 8 uses value bit 16 and mask bit 20; no other bit has a function.
// R11: single-octet writes are accepted and leave other octets untouched.
// R12: software writes 0 to every reserved bit.
// R13: after reset all value bits are 0 and reserved bits always read 0.
`ifndef GPMO_PARAMS_SVH
`define GPMO_PARAMS_SVH
`define GPMO_NPINS        9
`define GPMO_OFF_OUTVAL   8'h0C
`define GPMO_OUTVAL_RST   9'h000
`define GPMO_LO_VAL       0
`define GPMO_LO_MSK       4
`define GPMO_HI_VAL       8
`define GPMO_HI_MSK       12
`define GPMO_P8_VAL       16
`define GPMO_P8_MSK       20
`define GPMO_DIR_OUT      1'h0
`endif

// [src/gpmo_pkg.sv]
// types of the masked gpio output-value block
// assumes gpmo_params.svh for the numeric constants
package gpmo_pkg;
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } gpmo_wb_req_s;
   typedef enum logic [1:0] {
      GPMO_IDLE = 2'b01,
      GPMO_ACK  = 2'b10
   } gpmo_bus_e;
   typedef struct packed {
      gpmo_bus_e   st;
      logic        err;
      logic [31:0] rdat;
      logic [8:0]  val;
   } gpmo_state_s;
endpackage

// [src/gpmo_pin_drv.sv]
// one pin's output driver
// assumes mode and direction come from elsewhere in the device
`include "gpmo_params.svh"
module gpmo_pin_drv
   import gpmo_pkg::*;
(
   input  wire logic core_clk,
   input  wire logic sys_rst,
   input  wire logic out_value_bit,
   input  wire logic gpio_sel,
   input  wire logic direction_bit,
   output logic      pin_o,
   output logic      pin_oe_n
);
   logic drive;
   assign drive = gpio_sel && (direction_bit == `GPMO_DIR_OUT); // R6 R7
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pin_o    <= 1'h0;
         pin_oe_n <= 1'h1;
      end else begin
         pin_o    <= out_value_bit; // R5
         pin_oe_n <= ~drive; // R6
      end
   end
   a_drive_follows: assert property (@(posedge core_clk) disable iff (sys_rst)
      (gpio_sel && !direction_bit) |=> !pin_oe_n && pin_o == $past(out_value_bit)) // R5
      else $error("driven pin does not follow stored value");
   a_input_floats: assert property (@(posedge core_clk) disable iff (sys_rst)
      (direction_bit || !gpio_sel) |=> pin_oe_n) // R7
      else $error("pin driven while not a gpio output");
endmodule

// [src/gpmo_top.sv]
// masked gpio output-value register with its pin drivers
// assumes a classic wishbone master on core_clk, synchronous reset
//
// Decided for this implementation: register access over Wishbone.
`include "gpmo_params.svh"
module gpmo_top
   import gpmo_pkg::*;
(
   input  wire logic                    core_clk,
   input  wire logic                    sys_rst,
   input  wire gpmo_wb_req_s            wb_req,
   output logic [31:0]                  wb_dat_o,
   output logic                         wb_ack_o,
   output logic                         wb_err_o,
   input  wire logic [`GPMO_NPINS-1:0]  gpio_sel,
   input  wire logic [`GPMO_NPINS-1:0]  direction_bit,
   output logic [`GPMO_NPINS-1:0]       pin_o,
   output logic [`GPMO_NPINS-1:0]       pin_oe_n,
   output logic [`GPMO_NPINS-1:0]       out_value_bit
);
   gpmo_state_s s_q;
   gpmo_state_s s_d;
   logic        req;
   logic        hit;
   logic [31:0] wmask;
   logic [31:0] wdat;
   logic [31:0] rd_word;
   logic [8:0]  new_val;
   logic [7:0]  reg_off;
   integer      i;

   assign req = wb_req.cyc && wb_req.stb && (s_q.st == GPMO_IDLE);
   assign reg_off = `GPMO_OFF_OUTVAL;
   // byte lanes within the word are not decoded
   assign hit = (wb_req.adr[7:2] == reg_off[7:2]);
   assign wmask = {{8{wb_req.sel[3]}}, {8{wb_req.sel[2]}},
                   {8{wb_req.sel[1]}}, {8{wb_req.sel[0]}}}; // R11
   assign wdat = wb_req.dat & wmask; // R11

   // value bit moves only where its own mask bit is set in this write
   always_comb begin
      new_val = s_q.val;
      for (i = 0; i < 4; i = i + 1) begin
         if (wdat[`GPMO_LO_MSK + i]) begin // R2 R8
            new_val[i] = wdat[`GPMO_LO_VAL + i];
         end
         if (wdat[`GPMO_HI_MSK + i]) begin // R2 R9
            new_val[4 + i] = wdat[`GPMO_HI_VAL + i];
         end
      end
      if (wdat[`GPMO_P8_MSK]) begin // R2 R10
         new_val[8] = wdat[`GPMO_P8_VAL];
      end
   end

   // masks and reserved bits read as zero
   always_comb begin
      rd_word = 32'h0000_0000; // R3 R13
      rd_word[`GPMO_LO_VAL +: 4] = s_q.val[3:0]; // R4 R8
      rd_word[`GPMO_HI_VAL +: 4] = s_q.val[7:4]; // R4 R9
      rd_word[`GPMO_P8_VAL] = s_q.val[8]; // R4 R10
   end

   always_comb begin
      s_d = s_q;
      case (s_q.st)
         GPMO_IDLE: begin
            if (req) begin
               s_d.st   = GPMO_ACK;
               s_d.err  = !hit;
               s_d.rdat = 32'h0000_0000;
               if (hit && wb_req.we) begin
                  s_d.val = new_val; // R1
               end else if (hit) begin
                  s_d.rdat = rd_word; // R4
               end
            end
         end
         GPMO_ACK: begin
            s_d.st  = GPMO_IDLE;
            s_d.err = 1'h0;
         end
         default: begin
            s_d.st = GPMO_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         s_q.st   <= GPMO_IDLE;
         s_q.err  <= 1'h0;
         s_q.rdat <= 32'h0000_0000;
         s_q.val  <= `GPMO_OUTVAL_RST; // R13
      end else begin
         s_q <= s_d;
      end
   end

   assign wb_ack_o      = (s_q.st == GPMO_ACK) && !s_q.err;
   assign wb_err_o      = (s_q.st == GPMO_ACK) && s_q.err;
   assign wb_dat_o      = s_q.rdat;
   assign out_value_bit = s_q.val;

   genvar g;
   generate
      for (g = 0; g < `GPMO_NPINS; g = g + 1) begin : g_pin
         gpmo_pin_drv u_drv (
            .core_clk      (core_clk),
            .sys_rst       (sys_rst),
            .out_value_bit (s_q.val[g]),
            .gpio_sel      (gpio_sel[g]),
            .direction_bit (direction_bit[g]),
            .pin_o         (pin_o[g]),
            .pin_oe_n      (pin_oe_n[g])
         );
      end
   endgenerate

   a_mask_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
      wb_ack_o |-> (wb_dat_o & 32'hFFFE_F0F0) == 32'h0000_0000) // R3
      else $error("mask or reserved bit read as one");
   a_unmapped_err: assert property (@(posedge core_clk) disable iff (sys_rst)
      (req && !hit) |=> wb_err_o && s_q.val == $past(s_q.val)) // R2
      else $error("unmapped access not refused");
   a_unmasked_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
      (req && hit && wb_req.we && !(wb_req.sel[0] && wb_req.dat[4]))
      |=> s_q.val[0] == $past(s_q.val[0])) // R2
      else $error("pin 0 changed without its mask");
   a_masked_write: assert property (@(posedge core_clk) disable iff (sys_rst)
      (req && hit && wb_req.we && wb_req.sel[2] && wb_req.dat[20])
      |=> s_q.val[8] == $past(wb_req.dat[16])) // R10
      else $error("pin 8 missed a masked write");
   a_octet_isolated: assert property (@(posedge core_clk) disable iff (sys_rst)
      (req && hit && wb_req.we && !wb_req.sel[1])
      |=> s_q.val[7:4] == $past(s_q.val[7:4])) // R11
      else $error("unselected octet changed");
   a_read_value: assert property (@(posedge core_clk) disable iff (sys_rst)
      (req && hit && !wb_req.we) |=> wb_ack_o
      && wb_dat_o[3:0] == $past(s_q.val[3:0])
      && wb_dat_o[11:8] == $past(s_q.val[7:4])) // R4
      else $error("read does not show stored values");
   a_hi_write: assert property (@(posedge core_clk) disable iff (sys_rst)
      (req && hit && wb_req.we && wb_req.sel[1] && wb_req.dat[12])
      |=> s_q.val[4] == $past(wb_req.dat[8])) // R9
      else $error("pin 4 missed a masked write");
   a_reset_clear: assert property (@(posedge core_clk)
      $past(sys_rst) |-> s_q.val == 9'h000) // R13
      else $error("values not cleared by reset");
   a_lo_write: assert property (@(posedge core_clk) disable iff (sys_rst)
      (req && hit && wb_req.we && wb_req.sel[0] && wb_req.dat[7])
      |=> s_q.val[3] == $past(wb_req.dat[3])) // R8
      else $error("pin 3 missed a masked write");
endmodule

// [verification/gpmo_top_tb.sv]
// bench for the masked gpio output-value block, random and corner writes
// assumes gpmo_top answers at byte 0x0C over classic wishbone
`include "gpmo_params.svh"
module gpio_masked_output_reg_tb
   import gpmo_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0]  LEGAL = 32'h0011FFFF;
   logic                    core_clk, sys_rst, wb_ack_o, wb_err_o, er;
   gpmo_wb_req_s            wb_req;
   logic [31:0]             wb_dat_o, rd, d;
   logic [`GPMO_NPINS-1:0]  gpio_sel, direction_bit, pin_o, pin_oe_n;
   logic [`GPMO_NPINS-1:0]  out_value_bit, model, oe;
   logic [7:0]              a;
   logic [3:0]              s;
   int                      fail_count, checks_done;
   gpmo_top gpmo_top_i (.core_clk(core_clk), .sys_rst(sys_rst),
      .wb_req(wb_req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .wb_err_o(wb_err_o), .gpio_sel(gpio_sel),
      .direction_bit(direction_bit), .pin_o(pin_o), .pin_oe_n(pin_oe_n),
      .out_value_bit(out_value_bit));
   function automatic int vpos(int p);
      return p < 4 ? p : (p < 8 ? p + 4 : 16);
   endfunction
   // mask bit of each pin sits four above its value bit, same octet
   function automatic logic [8:0] upd(logic [8:0] v, logic [31:0] w,
                                      logic [3:0] m);
      for (int p = 0; p < 9; p++) begin
         if (m[vpos(p) / 8] && w[vpos(p) + 4])
            v[p] = w[vpos(p)];
      end
      return v;
   endfunction
   function automatic logic [31:0] rdexp(logic [8:0] v);
      logic [31:0] r;
      r = '0;
      for (int p = 0; p < 9; p++)
         r[vpos(p)] = v[p];
      return r;
   endfunction
   task automatic chk32(input logic [31:0] g, x, input string m);
      checks_done++;
      if (g !== x) begin
         fail_count++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, g, x);
      end
   endtask
   task automatic chk9(input logic [8:0] g, x, input string m);
      checks_done++;
      if (g !== x) begin
         fail_count++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, g, x);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] ad,
                      input logic [3:0] se, input logic [31:0] dt);
      int n;
      n = 0;
      @(posedge core_clk);
      wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: ad, sel: se, dat: dt};
      do begin
         @(posedge core_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
      if (n >= 20) begin
         fail_count++;
         $display("[FAIL] %0t no bus answer", $time);
      end
      rd = wb_dat_o;
      er = wb_err_o;
      wb_req.cyc <= 1'b0;
      wb_req.stb <= 1'b0;
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   initial begin
      #100000;
      fail_count++;
      $display("[FAIL] %0t watchdog expired", $time);
      summarize();
   end
   initial begin
      void'($urandom(32'h05F5DFB4));
      {wb_req, gpio_sel, model, checks_done, fail_count} = '0;
      direction_bit = 9'h1FF;
      sys_rst = 1'b1;
      repeat (5) @(posedge core_clk);
      sys_rst <= 1'b0;
      #1;
      chk9(out_value_bit, 9'h000, "reset value");
      chk9(pin_oe_n, 9'h1FF, "reset enable");
      for (int i = 0; i < 300; i++) begin
         s = (i < 2) ? 4'hF : 4'($urandom);
         d = (i == 1) ? 32'h00010F0F : (i == 0 ? LEGAL : $urandom & LEGAL);
         @(posedge core_clk);
         gpio_sel <= 9'($urandom);
         direction_bit <= 9'($urandom);
         bus(1'b1, 8'h0C | 8'($urandom % 4), s, d);
         model = upd(model, d, s);
         chk9({8'h00, er}, 9'h000, "write answer");
         chk9(out_value_bit, model, "stored value");
         bus(1'b0, 8'h0C, 4'hF, 32'h0);
         chk32(rd, rdexp(model), "read back");
         repeat (2) @(posedge core_clk);
         #1;
         oe = ~(gpio_sel & ~direction_bit);
         chk9(pin_oe_n, oe, "pin enable");
         chk9(pin_o & ~oe, model & ~oe, "pin level");
         if (i % 10 == 5) begin
            a = 8'($urandom);
            if (a[7:2] == 6'h03)
               a = a ^ 8'h40;
            bus(1'b1, a, 4'hF, LEGAL);
            chk9({8'h00, er}, 9'h001, "unmapped answer");
            chk9(out_value_bit, model, "unmapped effect");
         end
      end
      summarize();
   end
endmodule
